/* logic/jpr_pkg.sv */
package jpr_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // widths and codes
  localparam int          IR_W            = 4;        // instruction register width
  localparam int          IR_COUNT        = 16;       // codes the register can hold
  localparam logic [3:0]  IR_DEVICE_RESET = 4'hC;     // device_reset_instruction
  localparam logic [3:0]  IR_BYPASS       = 4'hF;     // loaded on test-logic-reset
  localparam logic [3:0]  IR_CAPTURE_PAT  = 4'h1;     // pattern captured in capture-ir
  localparam logic        RESET_DR_INIT   = 1'b0;     // reset data register after reset

  //////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int          DISABLE_CLEAR_CLOCKS = 2;   // chip clocks of pin reset to clear
  localparam int          RESET_TIMEOUT_CYCLES = 64;  // default hold after reset release

  //////////////////////////////////////////////////////////////////////////////
  // test port controller states, binary codes written out
  typedef enum logic [3:0] {
    TAP_RESET      = 4'h0,
    TAP_IDLE       = 4'h1,
    TAP_SEL_DR     = 4'h2,
    TAP_CAPTURE_DR = 4'h3,
    TAP_SHIFT_DR   = 4'h4,
    TAP_EXIT1_DR   = 4'h5,
    TAP_PAUSE_DR   = 4'h6,
    TAP_EXIT2_DR   = 4'h7,
    TAP_UPDATE_DR  = 4'h8,
    TAP_SEL_IR     = 4'h9,
    TAP_CAPTURE_IR = 4'hA,
    TAP_SHIFT_IR   = 4'hB,
    TAP_EXIT1_IR   = 4'hC,
    TAP_PAUSE_IR   = 4'hD,
    TAP_EXIT2_IR   = 4'hE,
    TAP_UPDATE_IR  = 4'hF
  } jpr_tap_state_type;

  // raw test pins arriving from the programmer
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jpr_pins_type;

  // serial output pin, three-state by enable
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } jpr_tdo_type;

endpackage : jpr_pkg

/* logic/jpr_sync.sv */
`timescale 1ns/1ps

module jpr_sync
  import jpr_pkg::*;
#(
  parameter int W = 1                  // number of independent levels
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // elaboration check: an empty synchroniser cannot be built
  if (W < 1) begin : g_bad_w
    $error("jpr_sync: width must be at least one");
  end

  logic [W-1:0] meta_q;                // first stage, read only by the second
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;                // second stage, safe to use
  logic [W-1:0] sync_d;

  //////////////////////////////////////////////////////////////////////////////
  // next values: frozen while the clock enable is low
  always_comb begin
    meta_d = clk_en ? async_in : meta_q;
    sync_d = clk_en ? meta_q   : sync_q;
  end

  // two flip-flops in series, only the clock-enable hold mux between them
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : jpr_sync

/* logic/jpr_reset_stretch.sv */
`timescale 1ns/1ps

module jpr_reset_stretch
  import jpr_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = RESET_TIMEOUT_CYCLES  // hold after request drops
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  input  wire logic reset_req,         // level, high while reset is asked for
  output logic      reset_hold         // level, registered hold ORed with the unregistered request
);

  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYCLES);

  // elaboration check: a zero time-out leaves the counter without a last value
  if (TIMEOUT_CYCLES < 1) begin : g_bad_timeout
    $error("jpr_reset_stretch: time-out must be at least one cycle");
  end

  logic [CW-1:0] cnt_q;                // cycles since the request dropped
  logic [CW-1:0] cnt_d;
  logic          hold_q;               // device held in reset
  logic          hold_d;

  //////////////////////////////////////////////////////////////////////////////
  // time-out: any request restarts the count, release only at the end
  always_comb begin
    cnt_d  = cnt_q;
    hold_d = hold_q;
    if (clk_en) begin
      if (reset_req) begin
        cnt_d  = '0;                   // R13
        hold_d = 1'b1;
      end else if (hold_q) begin
        if (cnt_q == LAST - CW'(1)) begin
          hold_d = 1'b0;               // R13
        end
        cnt_d = cnt_q + CW'(1);
      end else begin
        cnt_d = '0;
      end
    end
  end

  // comes out of power-up already in reset so the core starts clean
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= '0;
      hold_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_d;
      hold_q <= hold_d;
    end
  end

  assign reset_hold = hold_q | reset_req;  // R10

endmodule : jpr_reset_stretch

/* logic/jpr_front.sv */
// Operation
// R1 - programming needs only the four test pins
// R2 - port usable: fuse programmed, disable bit clear
// R3 - pin reset clears disable bit after two clocks
// R4 - programmer avoids reset trick for scan/debug
// R5 - all shift registers move lsb first
// R6 - four-bit instruction register selects data path
// R7 - run-test/idle yields internal clock pulses
// R8 - code C selects one-bit reset register
// R9 - reset instruction leaves test controller untouched
// R10 - device reset follows register, unlatched
// R11 - reset register shifts only in shift-dr
// R12 - programmer resets device before programming mode
// R13 - reset held for time-out after release
`timescale 1ns/1ps

module jpr_front
  import jpr_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = RESET_TIMEOUT_CYCLES  // reset time-out in ref_clk cycles
) (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              clk_en,
  input  jpr_pins_type           test_pins,
  input  wire logic              ext_reset_pin_n,
  input  wire logic              test_port_enable_fuse,
  input  wire logic              disable_bit_set,
  input  wire logic              disable_bit_clear,
  output jpr_tdo_type            tdo_out,
  output logic                   test_port_disable_bit,
  output logic                   test_port_active,
  output logic                   device_reset,
  output logic                   idle_clk_pulse,
  output logic [IR_W-1:0]        instr_out,
  output jpr_tap_state_type      tap_state
);

  localparam logic [1:0] DIS_LAST = 2'(DISABLE_CLEAR_CLOCKS - 1);

  // elaboration checks: code space and the two-bit clear counter
  if ((1 << IR_W) != IR_COUNT) begin : g_bad_ir_w
    $error("jpr_front: instruction width does not fit code space");
  end
  if (DISABLE_CLEAR_CLOCKS < 1 || DISABLE_CLEAR_CLOCKS > 4) begin : g_bad_clear
    $error("jpr_front: clear delay");
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  jpr_pins_type pins_s;                // test pins after two flip-flops
  logic         ext_reset_n_s;         // external reset after two flip-flops

  // tck, tms, tdi and the reset pin all come from outside this clock
  jpr_sync #(
    .W        (4)
  ) u_pin_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .clk_en   (clk_en),
    .async_in ({test_pins, ext_reset_pin_n}),
    .sync_out ({pins_s, ext_reset_n_s})
  );

  //////////////////////////////////////////////////////////////////////////////
  // tck edge finder

  logic tck_prev_q;                    // synced tck one cycle late
  logic tck_prev_d;
  logic tck_rise;                      // one-cycle pulse per rising tck
  logic tck_fall;                      // one-cycle pulse per falling tck

  // edges are seen on the synced copy only; tck must stay below ref_clk / 4
  always_comb begin
    tck_prev_d = clk_en ? pins_s.tck : tck_prev_q;
    tck_rise   = clk_en & pins_s.tck & ~tck_prev_q;
    tck_fall   = clk_en & ~pins_s.tck & tck_prev_q;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_prev_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // port-disable bit and its clearing by the external reset

  logic       dis_q;                   // port-disable control bit
  logic       dis_d;
  logic [1:0] dis_cnt_q;               // chip clocks seen with the pin reset low
  logic [1:0] dis_cnt_d;
  logic       port_ok;                 // test port may be used

  // the reset-driven clear wins: the core is in reset and cannot be writing
  always_comb begin
    dis_d     = dis_q;
    dis_cnt_d = dis_cnt_q;
    if (clk_en) begin
      if (!ext_reset_n_s && dis_q) begin
        if (dis_cnt_q == DIS_LAST) begin
          dis_d     = 1'b0;            // R3
          dis_cnt_d = '0;
        end else begin
          dis_cnt_d = dis_cnt_q + 2'd1;  // R3
        end
      end else begin
        dis_cnt_d = '0;
        if (disable_bit_set) begin
          dis_d = 1'b1;                // set beats a same-cycle clear
        end else if (disable_bit_clear) begin
          dis_d = 1'b0;
        end
      end
    end
    port_ok = test_port_enable_fuse & ~dis_q;  // R2
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dis_q     <= 1'b0;
      dis_cnt_q <= '0;
    end else begin
      dis_q     <= dis_d;
      dis_cnt_q <= dis_cnt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // test port controller state machine

  jpr_tap_state_type st_q;             // current controller state
  jpr_tap_state_type st_d;

  // walks the standard sixteen-state graph on each rising tck
  always_comb begin
    st_d = st_q;
    // a low clock enable freezes the forced reset as well
    if (clk_en && !port_ok) begin
      st_d = TAP_RESET;                // R2
    end else if (tck_rise) begin
      unique case (st_q)
        TAP_RESET:      st_d = pins_s.tms ? TAP_RESET     : TAP_IDLE;
        TAP_IDLE:       st_d = pins_s.tms ? TAP_SEL_DR    : TAP_IDLE;
        TAP_SEL_DR:     st_d = pins_s.tms ? TAP_SEL_IR    : TAP_CAPTURE_DR;
        TAP_CAPTURE_DR: st_d = pins_s.tms ? TAP_EXIT1_DR  : TAP_SHIFT_DR;
        TAP_SHIFT_DR:   st_d = pins_s.tms ? TAP_EXIT1_DR  : TAP_SHIFT_DR;
        TAP_EXIT1_DR:   st_d = pins_s.tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR:   st_d = pins_s.tms ? TAP_EXIT2_DR  : TAP_PAUSE_DR;
        TAP_EXIT2_DR:   st_d = pins_s.tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
        TAP_UPDATE_DR:  st_d = pins_s.tms ? TAP_SEL_DR    : TAP_IDLE;
        TAP_SEL_IR:     st_d = pins_s.tms ? TAP_RESET     : TAP_CAPTURE_IR;
        TAP_CAPTURE_IR: st_d = pins_s.tms ? TAP_EXIT1_IR  : TAP_SHIFT_IR;
        TAP_SHIFT_IR:   st_d = pins_s.tms ? TAP_EXIT1_IR  : TAP_SHIFT_IR;
        TAP_EXIT1_IR:   st_d = pins_s.tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR:   st_d = pins_s.tms ? TAP_EXIT2_IR  : TAP_PAUSE_IR;
        TAP_EXIT2_IR:   st_d = pins_s.tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
        TAP_UPDATE_IR:  st_d = pins_s.tms ? TAP_SEL_DR    : TAP_IDLE;
      endcase
    end
  end

  // only the chip reset and the port gate reach this; the reset register does not
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= TAP_RESET;
    end else begin
      st_q <= st_d;                    // R9
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // instruction and data registers

  logic [IR_W-1:0] ir_sh_q;            // instruction shift stage
  logic [IR_W-1:0] ir_sh_d;
  logic [IR_W-1:0] ir_q;               // active instruction
  logic [IR_W-1:0] ir_d;
  logic            rst_dr_q;           // one-bit reset data register
  logic            rst_dr_d;
  logic            byp_q;              // bypass bit for every other code
  logic            byp_d;
  logic            sel_reset;          // reset register is the data path

  // all but the bypass load in test-logic-reset moves on the rising tck; shifting is towards bit zero
  always_comb begin
    ir_sh_d   = ir_sh_q;
    ir_d      = ir_q;
    rst_dr_d  = rst_dr_q;
    byp_d     = byp_q;
    sel_reset = (ir_q == IR_DEVICE_RESET);  // R8
    if (clk_en && (st_q == TAP_RESET)) begin
      ir_d = IR_BYPASS;
    end
    if (tck_rise) begin
      unique case (st_q)
        TAP_CAPTURE_IR: ir_sh_d = IR_CAPTURE_PAT;
        TAP_SHIFT_IR:   ir_sh_d = {pins_s.tdi, ir_sh_q[IR_W-1:1]};  // R5
        TAP_UPDATE_IR:  ir_d    = ir_sh_q;  // R6
        TAP_CAPTURE_DR: byp_d   = 1'b0;
        TAP_SHIFT_DR: begin
          if (sel_reset) begin
            rst_dr_d = pins_s.tdi;     // R11
          end else begin
            byp_d = pins_s.tdi;
          end
        end
        default: ;                     // no register moves on a rising tck in the other states
      endcase
    end
  end

  // the reset register keeps its content across test-logic-reset so the core
  // stays held until the programmer shifts in a zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ir_sh_q  <= '0;
      ir_q     <= IR_BYPASS;
      rst_dr_q <= RESET_DR_INIT;
      byp_q    <= 1'b0;
    end else begin
      ir_sh_q  <= ir_sh_d;
      ir_q     <= ir_d;
      rst_dr_q <= rst_dr_d;
      byp_q    <= byp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial output, launched on the falling tck

  jpr_tdo_type tdo_q;                  // registered pin value and enable
  jpr_tdo_type tdo_d;

  // bit zero of the selected path leaves first
  always_comb begin
    tdo_d = tdo_q;
    if (clk_en && !port_ok) begin
      tdo_d = '0;
    end else if (tck_fall) begin
      unique case (st_q)
        TAP_SHIFT_IR: tdo_d = '{tdo: ir_sh_q[0], tdo_oe: 1'b1};  // R5
        TAP_SHIFT_DR: tdo_d = '{tdo: sel_reset ? rst_dr_q : byp_q, tdo_oe: 1'b1};
        default:      tdo_d = '{tdo: tdo_q.tdo, tdo_oe: 1'b0};
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tdo_q <= '0;
    end else begin
      tdo_q <= tdo_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // idle clock pulses

  logic idle_pulse_q;                  // one ref_clk pulse per tck in idle
  logic idle_pulse_d;

  // idle itself changes nothing else, so it stays a safe parking state
  always_comb begin
    idle_pulse_d = clk_en ? (tck_rise & (st_q == TAP_IDLE)) : idle_pulse_q;  // R7
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      idle_pulse_q <= 1'b0;
    end else begin
      idle_pulse_q <= idle_pulse_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // device reset: pin or register, then the time-out

  logic reset_req;                     // unlatched reset request

  // register content feeds straight through; no update stage in between
  assign reset_req = rst_dr_q | ~ext_reset_n_s;  // R10

  jpr_reset_stretch #(
    .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
  ) u_reset_stretch (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .clk_en     (clk_en),
    .reset_req  (reset_req),
    .reset_hold (device_reset)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs; no reset or clock pin is needed to run the port

  assign tdo_out               = tdo_q;  // R1
  assign test_port_disable_bit = dis_q;
  assign test_port_active      = port_ok;
  assign idle_clk_pulse        = idle_pulse_q;
  assign instr_out             = ir_q;
  assign tap_state             = st_q;

endmodule : jpr_front

/* verification/jpr_front_asserts.sv */
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// port-level checks of the programming front end
module jpr_front_asserts
  import jpr_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = RESET_TIMEOUT_CYCLES  // reset hold, from the top
) (
  input  wire logic            ref_clk,
  input  wire logic            rstn,
  input  wire logic            ext_reset_pin_n,
  input  wire logic            test_port_enable_fuse,
  input  jpr_tdo_type          tdo_out,
  input  wire logic            test_port_disable_bit,
  input  wire logic            test_port_active,
  input  wire logic            device_reset,
  input  wire logic            idle_clk_pulse,
  input  wire logic [IR_W-1:0] instr_out,
  input  jpr_tap_state_type    tap_state
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  int since_d;                        // next count
  int since_q;                        // edges since reset release, saturating

  // saturate so the count never wraps in a long run
  always_comb since_d = (since_q < TIMEOUT_CYCLES) ? since_q + 1 : since_q;

  // register the count
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) since_q <= 0;
    else since_q <= since_d;

  //////////////////////////////////////////////////////////////////////////////
  property p_active;
    test_port_active == (test_port_enable_fuse && !test_port_disable_bit);
  endproperty
  a_active: assert property (p_active)
    else $error("port active flag wrong");
  property p_refuse;
    !test_port_active |-> ##[0:3] (tap_state == TAP_RESET && !tdo_out.tdo_oe);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("inactive port not held in reset");
  property p_clear;
    (!ext_reset_pin_n)[*5] |-> !test_port_disable_bit;
  endproperty
  a_clear: assert property (p_clear)
    else $error("pin reset did not clear disable bit");
  property p_pinrst;
    (!ext_reset_pin_n)[*4] |-> device_reset;
  endproperty
  a_pinrst: assert property (p_pinrst)
    else $error("pin reset did not reset core");
  property p_oe;
    $rose(tdo_out.tdo_oe) |-> tap_state inside {TAP_SHIFT_DR, TAP_SHIFT_IR};
  endproperty
  a_oe: assert property (p_oe)
    else $error("tdo driven outside shift");
  property p_ir_tlr;
    (tap_state == TAP_RESET)[*2] |-> instr_out == IR_BYPASS;
  endproperty
  a_ir_tlr: assert property (p_ir_tlr)
    else $error("bypass not loaded in reset state");
  property p_ir_upd;
    $changed(instr_out) |-> tap_state inside {TAP_UPDATE_IR, TAP_RESET} ||
      $past(tap_state) inside {TAP_UPDATE_IR, TAP_RESET};
  endproperty
  a_ir_upd: assert property (p_ir_upd)
    else $error("instruction changed outside update");
  property p_idle;
    idle_clk_pulse |-> (tap_state == TAP_IDLE || $past(tap_state, 2) == TAP_IDLE)
      ##1 !idle_clk_pulse;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle pulse wrong");
  property p_tap_free;
    $rose(device_reset) |=> $stable(tap_state);
  endproperty
  a_tap_free: assert property (p_tap_free)
    else $error("core reset disturbed controller");
  property p_hold;
    since_q < TIMEOUT_CYCLES |-> device_reset;
  endproperty
  a_hold: assert property (p_hold)
    else $error("core left reset before time-out");
endmodule : jpr_front_asserts

bind jpr_front jpr_front_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_asserts (
  .ref_clk(ref_clk), .rstn(rstn), .ext_reset_pin_n(ext_reset_pin_n),
  .test_port_enable_fuse(test_port_enable_fuse), .tdo_out(tdo_out),
  .test_port_disable_bit(test_port_disable_bit), .test_port_active(test_port_active),
  .device_reset(device_reset), .idle_clk_pulse(idle_clk_pulse), .instr_out(instr_out),
  .tap_state(tap_state)
);

/* verification/jpr_prog_model.sv */
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// behavioural programmer: owns tck, tms, tdi and reads tdo, nothing else
module jpr_prog_model
  import jpr_pkg::*;
(
  output jpr_pins_type pins,
  input  jpr_tdo_type  tdo_in
);
  jpr_tdo_type tdo_seen;              // tdo sampled just before a shifting rise
  event        got;                   // one per sampled bit

  initial pins = 3'h0;

  // one 125 ns tck period; tck stands high between frames
  task automatic bit_op(input logic ms, input logic di);
    pins.tck = 1'b0;
    pins.tms = ms;
    pins.tdi = di;
    #62.5;
    tdo_seen = tdo_in;
    pins.tck = 1'b1;
    #62.5;
  endtask : bit_op

  // tms pattern lsb first; tdi toggles since nothing is shifted
  task automatic walk(input logic [7:0] ms, input int n);
    for (int i = 0; i < n; i++) bit_op(ms[i], ~pins.tdi);
  endtask : walk

  // a shifting bit whose tdo is handed to the watcher
  task automatic shift(input logic ms, input logic di);
    bit_op(ms, di);
    -> got;
  endtask : shift

  // idle to idle through shift-ir, code bit 0 first
  task automatic ir_load(input logic [3:0] code);
    walk(8'h03, 4);
    for (int i = 0; i < 4; i++) shift(i == 3, code[i]);
    walk(8'h01, 2);
  endtask : ir_load

  // idle to idle through shift-dr, two bits, b0 first
  task automatic dr2(input logic b0, input logic b1);
    walk(8'h01, 3);
    shift(1'b0, b0);
    shift(1'b1, b1);
    walk(8'h01, 2);
  endtask : dr2
endmodule : jpr_prog_model

/* verification/jpr_front_bench.sv */
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// self-checking bench: programmer model on the pins, watcher on the outputs
module jpr_front_bench;
  import jpr_pkg::*;
  localparam int TO = 4;              // short time-out keeps the run brief

  logic              ref_clk, rstn, clk_en, pin_rst_n, fuse, dis_set, dis_clr;
  jpr_pins_type      pins;            // from the model
  jpr_tdo_type       tdo;             // to the model
  logic              dis_bit, active, dev_rst, idle_pulse, track, cur;
  logic [IR_W-1:0]   instr, last_ir;
  jpr_tap_state_type state;
  int                num_errors, samples_checked, cyc, t0, d, n_idle, seed, r;
  logic [3:0]        ir_q[$];         // expected instructions
  logic              dr_q[$];         // expected core reset levels
  jpr_tdo_type       td_q[$];         // expected tdo bits

  always #2.5 ref_clk = ~ref_clk;

  jpr_front #(.TIMEOUT_CYCLES(TO)) i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .test_pins(pins),
    .ext_reset_pin_n(pin_rst_n), .test_port_enable_fuse(fuse),
    .disable_bit_set(dis_set), .disable_bit_clear(dis_clr), .tdo_out(tdo),
    .test_port_disable_bit(dis_bit), .test_port_active(active),
    .device_reset(dev_rst), .idle_clk_pulse(idle_pulse), .instr_out(instr),
    .tap_state(state)
  );
  jpr_prog_model i_prog (.pins(pins), .tdo_in(tdo));

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // watcher: each visible result takes the oldest note
  always @(posedge ref_clk) begin
    cyc++;
    if (state != TAP_EXIT1_DR) t0 = cyc;
    d = cyc - t0;
    if (rstn && instr !== last_ir) begin
      check(instr, ir_q.size() ? ir_q.pop_front() : 4'hX);
      last_ir = instr;
    end
    if (track && dev_rst !== cur) begin
      check(4'(dev_rst), 4'(dr_q.size() ? dr_q.pop_front() : 1'bx));
      // rise comes with the exit1-dr edge, fall after the full time-out
      check(4'(dev_rst ? (d == 1) : (d == TO + 1)), 4'h1);
      cur = dev_rst;
    end
    if (idle_pulse) n_idle++;
  end
  always @(i_prog.got) check({2'h0, i_prog.tdo_seen}, {2'h0, td_q.pop_front()});

  // hang guard, well past the expected run length
  initial begin
    #400000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    clk_en = 1'b1;
    pin_rst_n = 1'b1;
    fuse = 1'b1;
    dis_set = 1'b0;
    dis_clr = 1'b0;
    seed = 21885;
    track = 1'b0;
    cur = 1'b0;
    last_ir = 4'hF;
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    check(4'(dev_rst), 4'h1);
    repeat (TO + 4) @(negedge ref_clk);
    check(4'(dev_rst), 4'h0);
    #1.3 i_prog.walk(8'h1F, 6);
    track = 1'b1;
    // every code; only the reset code may move the core reset
    for (int c = 0; c < IR_COUNT; c++) begin
      r = $random(seed);
      ir_q.push_back(4'(c));
      for (int i = 0; i < 4; i++) td_q.push_back({IR_CAPTURE_PAT[i], 1'b1});
      i_prog.ir_load(4'(c));
      if (4'(c) == IR_DEVICE_RESET) begin
        // first bit keeps the level, so the change is timed from exit1-dr
        td_q.push_back({RESET_DR_INIT, 1'b1});
        td_q.push_back({1'b0, 1'b1});
        dr_q.push_back(1'b1);
        i_prog.dr2(1'b0, 1'b1);
        i_prog.walk(8'h0D, 5);
        n_idle = 0;
        i_prog.walk(8'h00, 5);
        check(4'(n_idle), 4'h5);
        td_q.push_back({1'b1, 1'b1});
        td_q.push_back({1'b1, 1'b1});
        dr_q.push_back(1'b0);
        i_prog.dr2(1'b1, 1'b0);
      end else begin
        td_q.push_back({1'b0, 1'b1});
        td_q.push_back({r[0], 1'b1});
        i_prog.dr2(r[0], r[1]);
      end
    end
    track = 1'b0;
    @(negedge ref_clk) dis_set = 1'b1;
    @(negedge ref_clk) dis_set = 1'b0;
    check(4'(active), 4'h0);
    #1.3 i_prog.walk(8'h03, 4);
    check(state, TAP_RESET);
    check(4'(tdo.tdo_oe), 4'h0);
    // pins used as plain port pins here, so the pin-reset path is fair
    @(negedge ref_clk) pin_rst_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    check(4'(dis_bit), 4'h1);
    @(negedge ref_clk);
    check(4'(dis_bit), 4'h0);
    check(4'(dev_rst), 4'h1);
    pin_rst_n = 1'b1;
    @(negedge ref_clk) dis_set = 1'b1;
    dis_clr = 1'b1;
    @(negedge ref_clk) dis_set = 1'b0;
    check(4'(dis_bit), 4'h1);
    @(negedge ref_clk) dis_clr = 1'b0;
    check(4'(dis_bit), 4'h0);
    fuse = 1'b0;
    #1 check(4'(active), 4'h0);
    fuse = 1'b1;
    tally_and_finish();
  end
endmodule : jpr_front_bench
